//--- hdl/plrc_consts.svh
`ifndef PLRC_CONSTS_SVH
`define PLRC_CONSTS_SVH

// Clock rate in MHz, used to turn microseconds into cycles.
`define PLRC_CLK_MHZ      25
// Command codes of the four registers.
`define PLRC_CMD_WP       8'h10
`define PLRC_CMD_DUTY     8'hBF
`define PLRC_CMD_REFRESH  8'hEC
`define PLRC_CMD_THR      8'hED
// Reset values.
`define PLRC_WP_RESET     8'h80
`define PLRC_CFG_RESET    8'h00
// Writable-bit masks; other bits are reserved and read as zero.
`define PLRC_WP_MASK      8'h80
`define PLRC_DUTY_MASK    8'h07
`define PLRC_REFRESH_MASK 8'h5F
`define PLRC_THR_MASK     8'h3F
// Field positions.
`define PLRC_WP_LOCK_BIT  7
`define PLRC_DUTY_HI      2
`define PLRC_RF_INT_HI    2
`define PLRC_RF_WIDTH_BIT 3
`define PLRC_RF_COUNT_BIT 4
`define PLRC_RF_BLANK_BIT 6
`define PLRC_THR_CCL_HI   2
`define PLRC_THR_CCL_LO   0
`define PLRC_THR_ACL_HI   5
`define PLRC_THR_ACL_LO   3
// Duty limits in tenths of a percent, by code.
`define PLRC_DUTY_C0      10'd917
`define PLRC_DUTY_C1      10'd958
`define PLRC_DUTY_C2      10'd875
`define PLRC_DUTY_C3      10'd833
`define PLRC_DUTY_C4      10'd792
`define PLRC_DUTY_C5      10'd750
`define PLRC_DUTY_FULL    10'd1000
// Refresh intervals in microseconds, by code.
`define PLRC_INT_US0      14'd500
`define PLRC_INT_US1      14'd100
`define PLRC_INT_US2      14'd200
`define PLRC_INT_US3      14'd300
`define PLRC_INT_US4      14'd750
`define PLRC_INT_US5      14'd1000
`define PLRC_INT_US6      14'd1500
`define PLRC_INT_US7      14'd2000
// Phase-drop blanking times in microseconds.
`define PLRC_BLANK_SHORT_US 14'd1500
`define PLRC_BLANK_LONG_US  14'd10000
// Refresh pulse width as a divisor of the PWM period.
`define PLRC_WIDTH_DIV_NARROW 4'd12
`define PLRC_WIDTH_DIV_WIDE   4'd6
// Refresh pulse counts.
`define PLRC_CNT_INIT_STD 5'd8
`define PLRC_CNT_RUN_STD  5'd4
`define PLRC_CNT_INIT_DBL 5'd16
`define PLRC_CNT_RUN_DBL  5'd8
// Kick-in thresholds in millivolts.
`define PLRC_CCL_TOP_MV   12'd2400
`define PLRC_ACL_TOP_MV   12'd2700
`define PLRC_THR_STEP_MV  12'd100

`endif

//--- hdl/plrc_pkg.sv
package plrc_pkg;
   // One register byte.
   typedef logic [7:0]  plrc_byte_t;
   // Duty limit in tenths of a percent.
   typedef logic [9:0]  plrc_permille_t;
   // Threshold voltage in millivolts.
   typedef logic [11:0] plrc_mv_t;
   // Outcome of one command.
   typedef enum logic [1:0] {
      PLRC_RSP_OK     = 2'h0,
      PLRC_RSP_LOCKED = 2'h1,
      PLRC_RSP_UNSUP  = 2'h2
   } plrc_rsp_t;
endpackage

//--- hdl/plrc_duty_map.sv
`timescale 1ns/1ps
`include "plrc_consts.svh"

// Maps a duty code to its limit and flags the unassigned codes.
module plrc_duty_map (
   // Code in.
   input  wire logic [2:0]               code,
   // Decoded limit.
   output logic                          valid,
   output plrc_pkg::plrc_permille_t      permille
);
   import plrc_pkg::*;

   // Codes six and seven have no limit, so they are flagged invalid.
   always_comb begin
      valid    = 1'b1;
      permille = `PLRC_DUTY_C0;
      case (code)
         3'h0: permille = `PLRC_DUTY_C0;
         3'h1: permille = `PLRC_DUTY_C1;
         3'h2: permille = `PLRC_DUTY_C2;
         3'h3: permille = `PLRC_DUTY_C3;
         3'h4: permille = `PLRC_DUTY_C4;
         3'h5: permille = `PLRC_DUTY_C5;
         default: valid = 1'b0;
      endcase
   end
endmodule

//--- hdl/plrc_regs.sv
`timescale 1ns/1ps
`include "plrc_consts.svh"

// What this block does
// - Duty code selects main switch on-duty cap.
// - Same cap limits flyback high/low side.
// - Refresh bits 2:0 select pulse spacing.
// - Refresh bit 3 selects pulse width.
// - Bit 4 clear: eight then four pulses.
// - Bit 4 set: sixteen then eight pulses.
// - Bit 6 selects phase-drop blanking time.
// - Threshold bits 2:0 set current-loop level.
// - Threshold bits 5:3 set average-limit level.
// - Write lock resets to 80h, locked.
// - Every register readable regardless of lock.
// - Lock bit set blocks all other writes.
// - Config registers are bytes resetting zero.
module plrc_regs #(
   // Cycles per microsecond; lower it to shorten simulations.
   parameter int CYC_PER_US = `PLRC_CLK_MHZ,
   // Width of the cycle-count outputs.
   parameter int CNT_W      = 24
) (
   // Clock, reset and enable.
   input  wire logic                     mclk,
   input  wire logic                     reset,
   input  wire logic                     ce,
   // Command port from the serial bus engine.
   input  wire logic                     cmd_valid,
   input  wire logic                     cmd_write,
   input  wire plrc_pkg::plrc_byte_t     cmd_code,
   input  wire plrc_pkg::plrc_byte_t     cmd_wdata,
   // Response, one enabled cycle after the command.
   output logic                          rsp_valid,
   output plrc_pkg::plrc_byte_t          rsp_rdata,
   output plrc_pkg::plrc_rsp_t           rsp_status,
   // Converter mode: high when stepping up.
   input  wire logic                     step_up,
   // Duty limits.
   output plrc_pkg::plrc_permille_t      main_limit,
   output plrc_pkg::plrc_permille_t      fly_hs_limit,
   output plrc_pkg::plrc_permille_t      fly_ls_limit,
   // Boot refresh settings.
   output logic [CNT_W-1:0]              refresh_interval_cyc,
   output logic [3:0]                    refresh_width_div,
   output logic [4:0]                    refresh_count_initial,
   output logic [4:0]                    refresh_count_running,
   output logic [CNT_W-1:0]              drop_blank_cyc,
   // Current loop thresholds.
   output plrc_pkg::plrc_mv_t            constant_current_loop_mv,
   output plrc_pkg::plrc_mv_t            average_current_limit_mv,
   // Write lock state.
   output logic                          write_locked
);
   import plrc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Threshold: top level less one step per code.
   function automatic plrc_mv_t thr_mv(input plrc_mv_t top,
                                       input logic [2:0] code);
      thr_mv = top - `PLRC_THR_STEP_MV * plrc_mv_t'(code);
   endfunction

   // Microseconds to cycles, cut to the output width.
   function automatic logic [CNT_W-1:0] us_to_cyc(input logic [13:0] us);
      us_to_cyc = CNT_W'(int'(us) * CYC_PER_US);
   endfunction

   // Refresh interval in microseconds by code.
   function automatic logic [13:0] refresh_us(input logic [2:0] code);
      case (code)
         3'h0:    refresh_us = `PLRC_INT_US0;
         3'h1:    refresh_us = `PLRC_INT_US1;
         3'h2:    refresh_us = `PLRC_INT_US2;
         3'h3:    refresh_us = `PLRC_INT_US3;
         3'h4:    refresh_us = `PLRC_INT_US4;
         3'h5:    refresh_us = `PLRC_INT_US5;
         3'h6:    refresh_us = `PLRC_INT_US6;
         default: refresh_us = `PLRC_INT_US7;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers and decode.

   plrc_byte_t     write_lock_control;        // Lock register.
   plrc_byte_t     max_duty_limit;            // Duty code as written.
   plrc_byte_t     bootstrap_refresh_control; // Refresh settings.
   plrc_byte_t     current_loop_thresholds;   // Threshold codes.
   logic [2:0]     duty_eff;                  // Last valid duty code.
   logic           acc;                       // Command taken.
   logic           wr_ok;                     // Write allowed.
   logic           known;                     // Code is implemented.
   logic           wmap_valid;                // Written duty code valid.
   plrc_permille_t wmap_permille;             // Its limit.
   logic           emap_valid;                // Always valid; checked below.
   plrc_permille_t emap_permille;             // Effective limit.
   plrc_byte_t     next_rdata;                // Read mux.

   assign acc = ce && cmd_valid;
   assign known = (cmd_code == `PLRC_CMD_WP) ||
                  (cmd_code == `PLRC_CMD_DUTY) ||
                  (cmd_code == `PLRC_CMD_REFRESH) ||
                  (cmd_code == `PLRC_CMD_THR);
   // lock gate.
   // The lock register itself stays writable, or the lock could never lift.
   assign wr_ok = acc && cmd_write && known &&
                  (!write_lock_control[`PLRC_WP_LOCK_BIT] ||
                   cmd_code == `PLRC_CMD_WP);

   // Judges the incoming duty code before it is taken.
   plrc_duty_map u_wmap (
      .code     (cmd_wdata[`PLRC_DUTY_HI:0]),
      .valid    (wmap_valid),
      .permille (wmap_permille)
   );

   // Maps the code that is in force.
   plrc_duty_map u_emap (
      .code     (duty_eff),
      .valid    (emap_valid),
      .permille (emap_permille)
   );

   // Lock register; only its top bit holds.
   always_ff @(posedge mclk) begin
      if (reset) begin
         write_lock_control <= `PLRC_WP_RESET;
      end else if (wr_ok && cmd_code == `PLRC_CMD_WP) begin
         write_lock_control <= cmd_wdata & `PLRC_WP_MASK;
      end
   end

   // Configuration registers; reserved bits are dropped on write.
   always_ff @(posedge mclk) begin
      if (reset) begin
         max_duty_limit            <= `PLRC_CFG_RESET;
         bootstrap_refresh_control <= `PLRC_CFG_RESET;
         current_loop_thresholds   <= `PLRC_CFG_RESET;
      end else if (wr_ok) begin
         case (cmd_code)
            `PLRC_CMD_DUTY: begin
               max_duty_limit <= cmd_wdata & `PLRC_DUTY_MASK;
            end
            `PLRC_CMD_REFRESH: begin
               bootstrap_refresh_control <= cmd_wdata & `PLRC_REFRESH_MASK;
            end
            `PLRC_CMD_THR: begin
               current_loop_thresholds <= cmd_wdata & `PLRC_THR_MASK;
            end
            default: begin
            end
         endcase
      end
   end

   // Effective duty code. An unassigned code is stored for readback
   // but the hardware keeps the last safe limit rather than guess one.
   always_ff @(posedge mclk) begin
      if (reset) begin
         duty_eff <= 3'(`PLRC_CFG_RESET);
      end else if (wr_ok && cmd_code == `PLRC_CMD_DUTY && wmap_valid) begin
         duty_eff <= cmd_wdata[`PLRC_DUTY_HI:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Response.

   // Read mux; reads never look at the lock.
   always_comb begin
      next_rdata = 8'h00;
      case (cmd_code)
         `PLRC_CMD_WP:      next_rdata = write_lock_control;
         `PLRC_CMD_DUTY:    next_rdata = max_duty_limit;
         `PLRC_CMD_REFRESH: next_rdata = bootstrap_refresh_control;
         `PLRC_CMD_THR:     next_rdata = current_loop_thresholds;
         default:           next_rdata = 8'h00;
      endcase
   end

   // One response per command; writes return zero data.
   always_ff @(posedge mclk) begin
      if (reset) begin
         rsp_valid  <= 1'b0;
         rsp_rdata  <= 8'h00;
         rsp_status <= PLRC_RSP_OK;
      end else if (ce) begin
         rsp_valid <= cmd_valid;
         rsp_rdata <= (cmd_valid && !cmd_write) ? next_rdata : 8'h00;
         if (!known) begin
            rsp_status <= PLRC_RSP_UNSUP;
         end else if (cmd_write && !wr_ok) begin
            rsp_status <= PLRC_RSP_LOCKED;
         end else begin
            rsp_status <= PLRC_RSP_OK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration outputs, registered one cycle behind the registers.

   // Duty limits; the unlimited side is left at full scale.
   always_ff @(posedge mclk) begin
      if (reset) begin
         main_limit   <= `PLRC_DUTY_C0;
         fly_hs_limit <= `PLRC_DUTY_C0;
         fly_ls_limit <= `PLRC_DUTY_FULL;
      end else if (ce) begin
         main_limit   <= emap_permille;
         fly_hs_limit <= step_up ? `PLRC_DUTY_FULL : emap_permille;
         fly_ls_limit <= step_up ? emap_permille : `PLRC_DUTY_FULL;
      end
   end

   // Refresh pulse settings.
   always_ff @(posedge mclk) begin
      if (reset) begin
         refresh_interval_cyc  <= us_to_cyc(`PLRC_INT_US0);
         refresh_width_div     <= `PLRC_WIDTH_DIV_NARROW;
         refresh_count_initial <= `PLRC_CNT_INIT_STD;
         refresh_count_running <= `PLRC_CNT_RUN_STD;
         drop_blank_cyc        <= us_to_cyc(`PLRC_BLANK_SHORT_US);
      end else if (ce) begin
         refresh_interval_cyc <= us_to_cyc(refresh_us(
            bootstrap_refresh_control[`PLRC_RF_INT_HI:0]));
         refresh_width_div <=
            bootstrap_refresh_control[`PLRC_RF_WIDTH_BIT] ?
            `PLRC_WIDTH_DIV_WIDE : `PLRC_WIDTH_DIV_NARROW;
         if (bootstrap_refresh_control[`PLRC_RF_COUNT_BIT]) begin
            refresh_count_initial <= `PLRC_CNT_INIT_DBL;
            refresh_count_running <= `PLRC_CNT_RUN_DBL;
         end else begin
            refresh_count_initial <= `PLRC_CNT_INIT_STD;
            refresh_count_running <= `PLRC_CNT_RUN_STD;
         end
         drop_blank_cyc <= us_to_cyc(
            bootstrap_refresh_control[`PLRC_RF_BLANK_BIT] ?
            `PLRC_BLANK_LONG_US : `PLRC_BLANK_SHORT_US);
      end
   end

   // Thresholds and lock flag.
   always_ff @(posedge mclk) begin
      if (reset) begin
         constant_current_loop_mv <= `PLRC_CCL_TOP_MV;
         average_current_limit_mv <= `PLRC_ACL_TOP_MV;
         write_locked             <= 1'b1;
      end else if (ce) begin
         constant_current_loop_mv <= thr_mv(`PLRC_CCL_TOP_MV,
            current_loop_thresholds[`PLRC_THR_CCL_HI:`PLRC_THR_CCL_LO]);
         average_current_limit_mv <= thr_mv(`PLRC_ACL_TOP_MV,
            current_loop_thresholds[`PLRC_THR_ACL_HI:`PLRC_THR_ACL_LO]);
         write_locked <= write_lock_control[`PLRC_WP_LOCK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence s_duty_wr;
      acc && cmd_write && cmd_code == `PLRC_CMD_DUTY &&
      !write_lock_control[`PLRC_WP_LOCK_BIT];
   endsequence

   sequence s_locked_wr;
      acc && cmd_write && cmd_code != `PLRC_CMD_WP &&
      write_lock_control[`PLRC_WP_LOCK_BIT];
   endsequence

   a_lock_reset: assert property (
      $past(reset) |-> write_lock_control == `PLRC_WP_RESET)
      else $error("lock register not 80h after reset");

   a_locked_write: assert property (
      s_locked_wr |=> $stable(max_duty_limit) &&
      $stable(bootstrap_refresh_control) &&
      $stable(current_loop_thresholds) && rsp_status != PLRC_RSP_OK)
      else $error("write passed while locked");

   a_read_open: assert property (
      acc && !cmd_write && cmd_code == `PLRC_CMD_DUTY
      |=> rsp_valid && rsp_rdata == $past(max_duty_limit))
      else $error("read did not return duty register");

   a_duty_apply: assert property (
      (s_duty_wr and wmap_valid) ##1 ce
      |=> main_limit == $past(wmap_permille, 2))
      else $error("duty limit not applied");

   a_duty_hold: assert property (
      (s_duty_wr and !wmap_valid) |=> duty_eff == $past(duty_eff))
      else $error("unassigned duty code took effect");

   a_eff_valid: assert property (emap_valid)
      else $error("unassigned duty code in force");

   a_fly_side: assert property (
      fly_hs_limit == `PLRC_DUTY_FULL || fly_ls_limit == `PLRC_DUTY_FULL)
      else $error("flyback cap on both sides");

   a_count_pair: assert property (
      refresh_count_initial == {refresh_count_running[3:0], 1'b0} &&
      (refresh_count_running == `PLRC_CNT_RUN_STD ||
       refresh_count_running == `PLRC_CNT_RUN_DBL))
      else $error("refresh counts inconsistent");

   a_thr_track: assert property (
      ce |=> constant_current_loop_mv == `PLRC_CCL_TOP_MV -
      `PLRC_THR_STEP_MV * plrc_mv_t'($past(current_loop_thresholds[2:0])))
      else $error("current loop threshold wrong");

   a_reserved_zero: assert property (
      (max_duty_limit & ~`PLRC_DUTY_MASK) == 8'h00 &&
      (bootstrap_refresh_control & ~`PLRC_REFRESH_MASK) == 8'h00 &&
      (current_loop_thresholds & ~`PLRC_THR_MASK) == 8'h00)
      else $error("reserved bit set");
endmodule

//--- tb/plrc_host.sv
`timescale 1ns/1ps

// Host side of the command port, as the system controller drives it.
module plrc_host (
   // Clock of the register bank.
   input  wire logic                  mclk,
   // Command port towards the bank.
   output logic                       cmd_valid,
   output logic                       cmd_write,
   output plrc_pkg::plrc_byte_t       cmd_code,
   output plrc_pkg::plrc_byte_t       cmd_wdata,
   // Response from the bank.
   input  wire logic                  rsp_valid,
   input  wire plrc_pkg::plrc_byte_t  rsp_rdata,
   input  wire plrc_pkg::plrc_rsp_t   rsp_status
);
   import plrc_pkg::*;

   // Idle values at time zero.
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code  = 8'h00;
      cmd_wdata = 8'h00;
   end

   // One command: raised after an edge, taken at the next one.
   // Released fields show the inverse, so nothing stale looks valid.
   task automatic xfer(input logic w, input plrc_byte_t c, input plrc_byte_t d,
                       output plrc_byte_t rd, output plrc_rsp_t st,
                       output logic vl);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_code  <= c;
      cmd_wdata <= d;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cmd_write <= ~w;
      cmd_code  <= ~c;
      cmd_wdata <= ~d;
      #1;
      rd = rsp_rdata;
      st = rsp_status;
      vl = rsp_valid;
   endtask
endmodule

//--- tb/tb_plrc_regs.sv
`timescale 1ns/1ps

// Self-checking bench for the configuration register bank.
module tb_plrc_regs;
   import plrc_pkg::*;
   // A short microsecond keeps the cycle counts small.
   localparam int CPU = 2;
   localparam int CW  = 24;
   logic           mclk, reset, ce, step_up;
   logic           cmd_valid, cmd_write, rsp_valid, write_locked, vl;
   plrc_byte_t     cmd_code, cmd_wdata, rsp_rdata, rd, d;
   plrc_rsp_t      rsp_status, st;
   plrc_permille_t main_limit, fly_hs_limit, fly_ls_limit;
   logic [CW-1:0]  refresh_interval_cyc, drop_blank_cyc;
   logic [3:0]     refresh_width_div;
   logic [4:0]     refresh_count_initial, refresh_count_running;
   plrc_mv_t       constant_current_loop_mv, average_current_limit_mv;
   logic [2:0]     eff;
   int             n_fail, n_checks, seed;
   plrc_byte_t     cfg [3] = '{8'hBF, 8'hEC, 8'hED};

   ////////////////////////////////////////////////////////////////////////
   plrc_regs #(.CYC_PER_US(CPU), .CNT_W(CW)) dut_u (
      .mclk(mclk), .reset(reset), .ce(ce),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_status(rsp_status), .step_up(step_up),
      .main_limit(main_limit), .fly_hs_limit(fly_hs_limit),
      .fly_ls_limit(fly_ls_limit),
      .refresh_interval_cyc(refresh_interval_cyc),
      .refresh_width_div(refresh_width_div),
      .refresh_count_initial(refresh_count_initial),
      .refresh_count_running(refresh_count_running),
      .drop_blank_cyc(drop_blank_cyc),
      .constant_current_loop_mv(constant_current_loop_mv),
      .average_current_limit_mv(average_current_limit_mv),
      .write_locked(write_locked));
   plrc_host host_u (
      .mclk(mclk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_status(rsp_status));

   ////////////////////////////////////////////////////////////////////////
   // Duty cap in tenths of a percent for a valid code.
   function automatic logic [9:0] duty_of(input logic [2:0] c);
      case (c)
         3'h0: return 10'h395;
         3'h1: return 10'h3BE;
         3'h2: return 10'h36B;
         3'h3: return 10'h341;
         3'h4: return 10'h318;
         default: return 10'h2EE;
      endcase
   endfunction

   // Refresh spacing in microseconds.
   function automatic logic [13:0] us_of(input logic [2:0] c);
      case (c)
         3'h0: return 14'h01F4;
         3'h1: return 14'h0064;
         3'h2: return 14'h00C8;
         3'h3: return 14'h012C;
         3'h4: return 14'h02EE;
         3'h5: return 14'h03E8;
         3'h6: return 14'h05DC;
         default: return 14'h07D0;
      endcase
   endfunction

   // Compares one value; an unknown never matches.
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One command; every command must be answered.
   task automatic acc(input logic w, input plrc_byte_t c, input plrc_byte_t x);
      host_u.xfer(w, c, x, rd, st, vl);
      check(24'(vl), 24'h1);
   endtask

   // Read that must succeed with a known value.
   task automatic rd_chk(input plrc_byte_t c, input plrc_byte_t exp);
      acc(1'b0, c, 8'h00);
      check(24'(rd), 24'(exp));
      check(24'(st), 24'(PLRC_RSP_OK));
   endtask

   // Verdict and end of run.
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Free-running clock at 25 MHz.
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // Watchdog: a hang counts as a mismatch.
   initial begin
      repeat (40000) @(posedge mclk);
      n_fail++;
      $display("MISMATCH at %0t: run did not finish", $time);
      summarize;
   end

   // Main sequence.
   initial begin
      seed = 57962;
      n_fail = 0;
      n_checks = 0;
      reset = 1'b1;
      ce = 1'b1;
      step_up = 1'b0;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      rd_chk(8'h10, 8'h80);
      rd_chk(8'hBF, 8'h00);
      rd_chk(8'hEC, 8'h00);
      rd_chk(8'hED, 8'h00);
      check(24'(write_locked), 24'h1);
      $display("test reset done");
      // Locked writes are refused and change nothing.
      for (int i = 0; i < 3; i++) begin
         acc(1'b1, cfg[i], 8'hFF);
         check(24'(st), 24'(PLRC_RSP_LOCKED));
         rd_chk(cfg[i], 8'h00);
      end
      $display("test lock done");
      acc(1'b1, 8'h10, 8'h7F);
      check(24'(st), 24'(PLRC_RSP_OK));
      rd_chk(8'h10, 8'h00);
      check(24'(write_locked), 24'h0);
      // Every duty code, in both converter modes.
      eff = 3'h0;
      for (int c = 0; c < 8; c++) begin
         d = plrc_byte_t'($random(seed));
         d[2:0] = c[2:0];
         acc(1'b1, 8'hBF, d);
         if (c < 6) begin
            eff = c[2:0];
         end
         rd_chk(8'hBF, {5'h00, c[2:0]});
         for (int s = 0; s < 2; s++) begin
            @(posedge mclk);
            step_up <= s[0];
            repeat (2) @(posedge mclk);
            #1;
            check(24'(main_limit), 24'(duty_of(eff)));
            check(24'(fly_hs_limit), s ? 24'h3E8 : 24'(duty_of(eff)));
            check(24'(fly_ls_limit), s ? 24'(duty_of(eff)) : 24'h3E8);
         end
      end
      $display("test duty done");
      // Refresh control across every spacing code and flag.
      for (int i = 0; i < 16; i++) begin
         d = plrc_byte_t'($random(seed));
         d[2:0] = i[2:0];
         d[3] = i[3];
         d[4] = i[2];
         d[6] = i[1];
         acc(1'b1, 8'hEC, d);
         rd_chk(8'hEC, d & 8'h5F);
         check(refresh_interval_cyc, 24'(us_of(d[2:0]) * CPU));
         check(24'(refresh_width_div), d[3] ? 24'h6 : 24'hC);
         check(24'(refresh_count_initial), d[4] ? 24'h10 : 24'h8);
         check(24'(refresh_count_running), d[4] ? 24'h8 : 24'h4);
         check(drop_blank_cyc, 24'((d[6] ? 10000 : 1500) * CPU));
      end
      $display("test refresh done");
      // Every threshold pair.
      for (int i = 0; i < 64; i++) begin
         d = plrc_byte_t'($random(seed));
         d[5:0] = i[5:0];
         acc(1'b1, 8'hED, d);
         rd_chk(8'hED, d & 8'h3F);
         check(24'(constant_current_loop_mv),
               24'(12'h960 - 12'h064 * d[2:0]));
         check(24'(average_current_limit_mv),
               24'(12'hA8C - 12'h064 * d[5:3]));
      end
      $display("test threshold done");
      // Relock, then a write must bounce.
      acc(1'b1, 8'h10, 8'h80);
      rd_chk(8'h10, 8'h80);
      acc(1'b1, 8'hED, 8'h00);
      check(24'(st), 24'(PLRC_RSP_LOCKED));
      rd_chk(8'hED, d & 8'h3F);
      check(24'(write_locked), 24'h1);
      $display("test relock done");
      // Clock enable low: a command is ignored and nothing moves.
      @(posedge mclk);
      ce <= 1'b0;
      host_u.xfer(1'b1, 8'h10, 8'h00, rd, st, vl);
      check(24'(vl), 24'h0);
      @(posedge mclk);
      ce <= 1'b1;
      rd_chk(8'h10, 8'h80);
      check(24'(write_locked), 24'h1);
      // An unknown code reads as zero and is flagged unsupported.
      acc(1'b0, 8'h00, 8'h00);
      check(24'(rd), 24'h0);
      check(24'(st), 24'(PLRC_RSP_UNSUP));
      $display("test enable done");
      // Reset in mid-run restores every default.
      @(posedge mclk);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      rd_chk(8'hED, 8'h00);
      rd_chk(8'hBF, 8'h00);
      check(24'(constant_current_loop_mv), 24'h960);
      check(24'(main_limit), 24'h395);
      check(24'(write_locked), 24'h1);
      $display("test mid reset done");
      summarize;
   end
endmodule
